// >>> rtl/int_glitch_filter.sv
// Glitch filter for the external interrupt input pads
// Assumes inputs synchronous to clk
`timescale 1ns/1ns
`include "port_pad_defs.svh"
module int_glitch_filter
#(
    parameter int WIDTH = 3,
    parameter int COUNT = `FILTER_CYCLES
)
(
    input  wire logic             clk,
    input  wire logic             arst_n,
    input  wire logic             enable,
    input  wire logic [WIDTH-1:0] rawIn,
    output logic      [WIDTH-1:0] cleanOut
);
    localparam int CW = $clog2(COUNT + 1);

    logic [CW-1:0] cnt_reg [WIDTH];

    generate
        if (WIDTH < 1 || COUNT < 1)
        begin : g_bad
            $error("int_glitch_filter: WIDTH and COUNT must be >= 1");
        end
    endgenerate

    // ----------------------------------------------------------------
    // Level must stand for COUNT cycles before it passes
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cleanOut <= '0;
            for (int i = 0; i < WIDTH; i++)
                cnt_reg[i] <= '0;
        end
        else
        begin
            for (int i = 0; i < WIDTH; i++)
            begin
                if (rawIn[i] == cleanOut[i])
                    cnt_reg[i] <= '0;
                else if (!enable || cnt_reg[i] == CW'(COUNT - 1))
                begin
                    cleanOut[i] <= rawIn[i];
                    cnt_reg[i]  <= '0;
                end
                else
                    cnt_reg[i] <= cnt_reg[i] + 1'b1;
            end
        end
    end

    a_filter_bypass: assert property (@(posedge clk) disable iff (!arst_n)
        !enable && !$past(enable) |-> cleanOut == $past(rawIn))
        else $error("Unfiltered input did not pass in one cycle");
endmodule

// >>> rtl/port_pad_control.sv
// Pad control for five 8-bit ports with system controls, control registers A and B key-protected
// Assumes an SFR bus synchronous to clk and pads taking enable-low drive
`timescale 1ns/1ns
`include "port_pad_defs.svh"
module port_pad_control
#(
    parameter int PORTS        = 5,
    parameter int FILTER_COUNT = `FILTER_CYCLES
)
(
    input  wire logic          clk,
    input  wire logic          arst_n,
    input  wire logic [7:0]    sfrAddr,
    input  wire logic          sfrWrite,
    input  wire logic          sfrRead,
    input  wire logic [7:0]    sfrWdata,
    output logic      [7:0]    sfrRdata,
    input  wire logic [39:0]   padIn,
    output logic      [39:0]   padOut,
    output logic      [39:0]   padOutEn_n,
    output logic      [39:0]   pullUpOn,
    output logic      [39:0]   pullDownOn,
    output logic      [4:0]    hysteresisOff,
    output logic      [4:0]    slewLimit,
    output logic      [7:0]    analogOn,
    input  wire logic          sysClkTap,
    input  wire logic [2:0]    compareOut,
    input  wire logic [2:0]    compareActive,
    input  wire logic          audioOn,
    input  wire logic          audioPlus,
    input  wire logic          audioMinus,
    input  wire logic [2:0]    intPadRaw,
    output logic      [2:0]    intPadClean,
    output logic               adcClockDoubler,
    output logic               lowVoltageResetOff
);
    logic [7:0]  data_reg    [PORTS];
    logic [7:0]  applied_reg [PORTS];
    logic [7:0]  pu_reg      [PORTS];
    logic [7:0]  pd_reg      [PORTS];
    logic [7:0]  ctrlB_reg;
    logic [7:0]  ctrlA_reg;
    logic [7:0]  slew_reg;
    logic [7:0]  key_reg;
    logic [39:0] padSample_reg;
    logic [2:0]  stagger_reg;
    logic [39:0] puVec;
    logic [39:0] pdVec;
    logic [39:0] dataVec;
    logic [39:0] anVec;
    logic [39:0] altMask;
    logic [39:0] altData;
    port_pad_pkg::unlock_state_type key_reg_state;
    port_pad_pkg::reg_sel_type      sel;
    logic        protOk;

    generate
        if (PORTS != 5)
        begin : g_bad
            $error("port_pad_control: PORTS must be 5");
        end
    endgenerate

    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------
    function automatic port_pad_pkg::reg_sel_type decode(
        input logic [7:0] a);
        port_pad_pkg::reg_sel_type s;
        s.kind = port_pad_pkg::SEL_NONE;
        s.idx  = 3'h0;
        if (a == `OFS_PORT0_DATA)
            s = '{port_pad_pkg::SEL_DATA, 3'h0};
        else if (a == `OFS_PORT1_DATA)
            s = '{port_pad_pkg::SEL_DATA, 3'h1};
        else if (a == `OFS_PORT2_DATA)
            s = '{port_pad_pkg::SEL_DATA, 3'h2};
        else if (a == `OFS_PORT3_DATA)
            s = '{port_pad_pkg::SEL_DATA, 3'h3};
        else if (a == `OFS_PORT4_DATA)
            s = '{port_pad_pkg::SEL_DATA, 3'h4};
        else if (a == `OFS_PORT0_PU)
            s = '{port_pad_pkg::SEL_PU, 3'h0};
        else if (a == `OFS_PORT0_PD)
            s = '{port_pad_pkg::SEL_PD, 3'h0};
        else if (a == `OFS_PORT1_PU)
            s = '{port_pad_pkg::SEL_PU, 3'h1};
        else if (a == `OFS_PORT1_PD)
            s = '{port_pad_pkg::SEL_PD, 3'h1};
        else if (a == `OFS_PORT2_PU)
            s = '{port_pad_pkg::SEL_PU, 3'h2};
        else if (a == `OFS_PORT2_PD)
            s = '{port_pad_pkg::SEL_PD, 3'h2};
        else if (a == `OFS_PORT3_PU)
            s = '{port_pad_pkg::SEL_PU, 3'h3};
        else if (a == `OFS_PORT3_PD)
            s = '{port_pad_pkg::SEL_PD, 3'h3};
        else if (a == `OFS_PORT4_PU)
            s = '{port_pad_pkg::SEL_PU, 3'h4};
        else if (a == `OFS_PORT4_PD)
            s = '{port_pad_pkg::SEL_PD, 3'h4};
        else if (a == `OFS_CTRL_B)
            s.kind = port_pad_pkg::SEL_CTRL_B;
        else if (a == `OFS_SLEW)
            s.kind = port_pad_pkg::SEL_SLEW;
        else if (a == `OFS_CTRL_A)
            s.kind = port_pad_pkg::SEL_CTRL_A;
        else if (a == `OFS_ANALOG)
            s.kind = port_pad_pkg::SEL_ANALOG;
        else if (a == `OFS_UNLOCK_KEY)
            s.kind = port_pad_pkg::SEL_KEY;
        return s;
    endfunction

    assign sel    = decode(sfrAddr);
    assign protOk = key_reg_state == port_pad_pkg::KEY_OPEN;

    // ----------------------------------------------------------------
    // Unlock sequence
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            key_reg_state <= port_pad_pkg::KEY_LOCKED;
            key_reg       <= 8'h00;
        end
        else if (sfrWrite)
        begin
            if (sel.kind == port_pad_pkg::SEL_KEY)
            begin
                key_reg <= sfrWdata;
                case (key_reg_state)
                    port_pad_pkg::KEY_LOCKED:
                        key_reg_state <= (sfrWdata == `KEY_FIRST) ?
                            port_pad_pkg::KEY_FIRST :
                            port_pad_pkg::KEY_LOCKED;
                    port_pad_pkg::KEY_FIRST:
                        key_reg_state <= (sfrWdata == `KEY_SECOND) ?
                            port_pad_pkg::KEY_OPEN :
                            (sfrWdata == `KEY_FIRST) ? port_pad_pkg::KEY_FIRST :
                            port_pad_pkg::KEY_LOCKED;
                    default:
                        key_reg_state <= (sfrWdata == `KEY_FIRST) ?
                            port_pad_pkg::KEY_FIRST :
                            port_pad_pkg::KEY_LOCKED;
                endcase
            end
            else if (sel.kind == port_pad_pkg::SEL_CTRL_A ||
                     sel.kind == port_pad_pkg::SEL_CTRL_B)
                key_reg_state <= port_pad_pkg::KEY_LOCKED;
        end
    end

    // ----------------------------------------------------------------
    // Port registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            for (int p = 0; p < PORTS; p++)
            begin
                data_reg[p] <= `RST_DATA;
                pu_reg[p]   <= `RST_PULL;
                pd_reg[p]   <= `RST_PULL;
            end
        end
        else if (sfrWrite)
        begin
            if (sel.kind == port_pad_pkg::SEL_DATA)
                data_reg[sel.idx] <= sfrWdata;
            else if (sel.kind == port_pad_pkg::SEL_PU)
                pu_reg[sel.idx] <= sfrWdata;
            else if (sel.kind == port_pad_pkg::SEL_PD)
                pd_reg[sel.idx] <= sfrWdata;
        end
    end

    // ----------------------------------------------------------------
    // System control registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ctrlA_reg <= `RST_CTRL;
            ctrlB_reg <= `RST_CTRL;
            slew_reg  <= `RST_SLEW;
            analogOn  <= `RST_ANALOG;
        end
        else if (sfrWrite)
        begin
            if (sel.kind == port_pad_pkg::SEL_CTRL_A && protOk)
                ctrlA_reg <= sfrWdata;
            else if (sel.kind == port_pad_pkg::SEL_CTRL_B && protOk)
                ctrlB_reg <= sfrWdata;
            else if (sel.kind == port_pad_pkg::SEL_SLEW)
                slew_reg <= sfrWdata;
            else if (sel.kind == port_pad_pkg::SEL_ANALOG)
                analogOn <= sfrWdata;
        end
    end

    assign slewLimit          = slew_reg[4:0];
    assign hysteresisOff      = {ctrlA_reg[`CA_HYST4_OFF],
                                 ctrlB_reg[3:0]};
    assign adcClockDoubler    = ctrlB_reg[`CB_ADC_DOUBLE];
    assign lowVoltageResetOff = ctrlA_reg[`CA_LVR_OFF];

    // ----------------------------------------------------------------
    // Output staggering
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            stagger_reg <= 3'h0;
            for (int p = 0; p < PORTS; p++)
                applied_reg[p] <= `RST_DATA;
        end
        else
        begin
            stagger_reg <= (stagger_reg == 3'(PORTS - 1)) ?
                3'h0 : stagger_reg + 3'h1;
            for (int p = 0; p < PORTS; p++)
                if (!ctrlB_reg[`CB_STAGGER] || stagger_reg == 3'(p))
                    applied_reg[p] <= data_reg[p];
        end
    end

    // ----------------------------------------------------------------
    // Pad drive
    // ----------------------------------------------------------------
    always_comb
    begin
        for (int p = 0; p < PORTS; p++)
        begin
            puVec[p*8 +: 8]   = pu_reg[p];
            pdVec[p*8 +: 8]   = pd_reg[p];
            dataVec[p*8 +: 8] = applied_reg[p];
        end
        anVec   = {32'h0, analogOn};
        altMask = '0;
        altData = '0;
        altMask[`PIN_SYSCLK] = ctrlA_reg[`CA_SYSCLK_OUT];
        altData[`PIN_SYSCLK] = sysClkTap;
        altMask[`PIN_COMPARE1 +: 3] =
            compareActive & {3{~ctrlA_reg[`CA_COMPARE_OFF]}};
        altData[`PIN_COMPARE1 +: 3] = compareOut;
        altMask[`PIN_AUDIO_PLUS] = audioOn;
        altData[`PIN_AUDIO_PLUS] = audioPlus;
        altMask[`PIN_AUDIO_MINUS] =
            audioOn & ~ctrlA_reg[`CA_AUDIO_MINUS_OFF];
        altData[`PIN_AUDIO_MINUS] = audioMinus;
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            padOut     <= '0;
            padOutEn_n <= '1;
            pullUpOn   <= '0;
            pullDownOn <= '0;
        end
        else
        begin
            padOut <= (altMask & altData) |
                      (~altMask & puVec & pdVec & dataVec);
            padOutEn_n <= ~(((puVec & pdVec) | ~dataVec | altMask) &
                            ~anVec);
            pullUpOn   <= puVec & ~pdVec & dataVec & ~altMask &
                          ~anVec;
            pullDownOn <= pdVec & ~puVec & dataVec & ~altMask &
                          ~anVec;
        end
    end

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            padSample_reg <= '1;
        else
            padSample_reg <= padIn;
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            sfrRdata <= 8'h00;
        else if (sfrRead)
        begin
            case (sel.kind)
                port_pad_pkg::SEL_DATA:
                    sfrRdata <= padSample_reg[sel.idx*8 +: 8];
                port_pad_pkg::SEL_PU:     sfrRdata <= pu_reg[sel.idx];
                port_pad_pkg::SEL_PD:     sfrRdata <= pd_reg[sel.idx];
                port_pad_pkg::SEL_CTRL_A: sfrRdata <= ctrlA_reg;
                port_pad_pkg::SEL_CTRL_B: sfrRdata <= ctrlB_reg;
                port_pad_pkg::SEL_SLEW:   sfrRdata <= slew_reg;
                port_pad_pkg::SEL_ANALOG: sfrRdata <= analogOn;
                port_pad_pkg::SEL_KEY:    sfrRdata <= key_reg;
                default:                  sfrRdata <= 8'h00;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Interrupt pad filter
    // ----------------------------------------------------------------
    int_glitch_filter #(.WIDTH(3), .COUNT(FILTER_COUNT)) u_filter
    (
        .clk      (clk),
        .arst_n   (arst_n),
        .enable   (ctrlB_reg[`CB_INT_FILTER]),
        .rawIn    (intPadRaw),
        .cleanOut (intPadClean)
    );

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    a_key_gate: assert property (
        sfrWrite && !protOk &&
        (sel.kind == port_pad_pkg::SEL_CTRL_A ||
         sel.kind == port_pad_pkg::SEL_CTRL_B)
        |=> $stable(ctrlA_reg) && $stable(ctrlB_reg))
        else $error("Protected write took effect while locked");
    a_key_open: assert property (
        sfrWrite && sel.kind == port_pad_pkg::SEL_KEY &&
        sfrWdata == `KEY_FIRST ##1
        sfrWrite && sel.kind == port_pad_pkg::SEL_KEY &&
        sfrWdata == `KEY_SECOND |=> protOk)
        else $error("Unlock sequence did not open");
    a_both_drive: assert property (
        1'b1 |=> (padOutEn_n & $past(puVec & pdVec & ~anVec)) == '0)
        else $error("Pin with both pulls not driven");
    a_analog_float: assert property (
        1'b1 |=> &(padOutEn_n | ~$past(anVec)) &&
        ((pullUpOn | pullDownOn) & $past(anVec)) == '0)
        else $error("Analog pin not floating");
    a_pull_high: assert property (
        1'b1 |=> (~pullUpOn & $past(puVec & ~pdVec & dataVec &
        ~altMask & ~anVec)) == '0)
        else $error("Pull-up not applied");
    a_read_pins: assert property (
        sfrRead && sel.kind == port_pad_pkg::SEL_DATA && sel.idx == 3'h0
        |=> sfrRdata == $past(padSample_reg[7:0]))
        else $error("Data read did not return pins");
    a_slew_write: assert property (
        sfrWrite && sel.kind == port_pad_pkg::SEL_SLEW
        |=> slewLimit == $past(sfrWdata[4:0]))
        else $error("Slew bits not updated");
    a_clk_route: assert property (
        ctrlA_reg[`CA_SYSCLK_OUT] && !anVec[`PIN_SYSCLK]
        |=> padOut[`PIN_SYSCLK] == $past(sysClkTap) &&
        !padOutEn_n[`PIN_SYSCLK])
        else $error("System clock not routed to pin");

    c_unlock: cover property (protOk ##1 sfrWrite &&
        sel.kind == port_pad_pkg::SEL_CTRL_A);
    c_output_mode: cover property (|(~padOutEn_n & padOut));
    c_stagger: cover property (ctrlB_reg[`CB_STAGGER] && sfrWrite &&
        sel.kind == port_pad_pkg::SEL_DATA);
endmodule

// >>> rtl/port_pad_defs.svh
// Register offsets, reset values, field positions and timing counts
// Assumes inclusion by bare name from the pad control files
`ifndef PORT_PAD_DEFS_SVH
`define PORT_PAD_DEFS_SVH
// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define OFS_PORT0_DATA     8'h80
`define OFS_PORT1_DATA     8'h90
`define OFS_PORT2_DATA     8'ha0
`define OFS_PORT3_DATA     8'hb0
`define OFS_PORT4_DATA     8'ha1
`define OFS_PORT0_PU       8'h9a
`define OFS_PORT0_PD       8'h9b
`define OFS_PORT1_PU       8'h9c
`define OFS_PORT1_PD       8'h9d
`define OFS_PORT2_PU       8'h9e
`define OFS_PORT2_PD       8'h9f
`define OFS_PORT3_PU       8'ha2
`define OFS_PORT3_PD       8'ha3
`define OFS_PORT4_PU       8'ha4
`define OFS_PORT4_PD       8'ha5
`define OFS_CTRL_B         8'ha7
`define OFS_SLEW           8'had
`define OFS_CTRL_A         8'hae
`define OFS_ANALOG         8'hf3
`define OFS_UNLOCK_KEY     8'hef
// ----------------------------------------------------------------
// Reset values and unlock sequence
// ----------------------------------------------------------------
`define RST_DATA           8'hff
`define RST_PULL           8'h00
`define RST_SLEW           8'hff
`define RST_CTRL           8'h00
`define RST_ANALOG         8'h00
`define KEY_FIRST          8'hff
`define KEY_SECOND         8'h00
// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CB_ADC_DOUBLE      7
`define CB_INT_FILTER      5
`define CB_STAGGER         4
`define CA_LVR_OFF         7
`define CA_AUDIO_MINUS_OFF 4
`define CA_SYSCLK_OUT      2
`define CA_COMPARE_OFF     1
`define CA_HYST4_OFF       0
`define PIN_SYSCLK         29
`define PIN_AUDIO_MINUS    30
`define PIN_AUDIO_PLUS     31
`define PIN_COMPARE1       9
// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS      4
`define FILTER_TIME_NS     2000
`define FILTER_CYCLES \
    ((`FILTER_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// >>> rtl/port_pad_pkg.sv
// Types shared by the pad control block
// Assumes nothing of its surroundings
package port_pad_pkg;
    typedef enum logic [2:0]
    {
        KEY_LOCKED = 3'b001,
        KEY_FIRST  = 3'b010,
        KEY_OPEN   = 3'b100
    } unlock_state_type;

    typedef enum logic [3:0]
    {
        SEL_NONE, SEL_DATA, SEL_PU, SEL_PD, SEL_CTRL_B,
        SEL_SLEW, SEL_CTRL_A, SEL_ANALOG, SEL_KEY
    } reg_kind_type;

    typedef struct packed
    {
        reg_kind_type kind;
        logic [2:0]   idx;
    } reg_sel_type;
endpackage

// >>> tb/tb_port_pad_control.sv
// Self-checking bench for the pad control block
// Assumes the pad control sources are compiled before it
`timescale 1ns/1ns
module tb_port_pad_control;
    logic        clk = 0;
    logic        arst_n = 0;
    logic [7:0]  sfrAddr = 8'h00;
    logic        sfrWrite = 0;
    logic        sfrRead = 0;
    logic [7:0]  sfrWdata = 8'h00;
    logic [7:0]  sfrRdata;
    logic [39:0] padIn = 40'h00;
    logic [39:0] padOut;
    logic [39:0] padOutEn_n;
    logic [39:0] pullUpOn;
    logic [39:0] pullDownOn;
    logic [4:0]  hysteresisOff;
    logic [4:0]  slewLimit;
    logic [7:0]  analogOn;
    logic        sysClkTap = 0;
    logic [2:0]  compareOut = 3'h5;
    logic [2:0]  compareActive = 3'h0;
    logic        audioOn = 0;
    logic        audioPlus = 1;
    logic        audioMinus = 0;
    logic [2:0]  intPadRaw = 3'h0;
    logic [2:0]  intPadClean;
    logic        adcClockDoubler;
    logic        lowVoltageResetOff;
    int          failures = 0;
    int          n_checks = 0;
    logic [7:0]  rv;
    logic [7:0]  an;
    logic [39:0] d;
    logic [39:0] u;
    logic [39:0] q;
    logic [39:0] e;
    logic [39:0] m;
    int          cyc = 0;
    int          t0 = 0;
    logic [7:0]  oD [5] = '{8'h80, 8'h90, 8'ha0, 8'hb0, 8'ha1};
    logic [7:0]  oU [5] = '{8'h9a, 8'h9c, 8'h9e, 8'ha2, 8'ha4};
    logic [7:0]  oP [5] = '{8'h9b, 8'h9d, 8'h9f, 8'ha3, 8'ha5};

    port_pad_control #(.FILTER_COUNT(8)) i_dut
    (
        .clk, .arst_n, .sfrAddr, .sfrWrite, .sfrRead, .sfrWdata,
        .sfrRdata, .padIn, .padOut, .padOutEn_n, .pullUpOn,
        .pullDownOn, .hysteresisOff, .slewLimit, .analogOn,
        .sysClkTap, .compareOut, .compareActive, .audioOn,
        .audioPlus, .audioMinus, .intPadRaw, .intPadClean,
        .adcClockDoubler, .lowVoltageResetOff
    );

    always #2 clk = ~clk;

    always @(posedge clk)
        cyc++;

    // ------------------------------------------------------------
    // Bus cycles and comparison
    // ------------------------------------------------------------
    task automatic chk(input logic [39:0] s, input logic [39:0] x);
        n_checks++;
        if (s !== x)
        begin
            failures++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, s, x);
        end
    endtask

    task automatic tk(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        #1 sfrAddr = a;
        sfrWdata = v;
        sfrWrite = 1;
        @(posedge clk);
        #1 sfrWrite = 0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk);
        #1 sfrAddr = a;
        sfrRead = 1;
        @(posedge clk);
        #1 sfrRead = 0;
        v = sfrRdata;
    endtask

    task automatic unlock;
        @(posedge clk);
        #1 sfrAddr = 8'hef;
        sfrWdata = 8'hff;
        sfrWrite = 1;
        @(posedge clk);
        #1 sfrWdata = 8'h00;
        @(posedge clk);
        #1 sfrWrite = 0;
    endtask

    task summarize;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial
    begin
        #200000;
        failures++;
        summarize;
    end

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial
    begin
        void'($urandom(66));
        tk(16);
        arst_n = 1;
        tk(2);
        chk(padOutEn_n, 40'hffffffffff);
        chk(pullUpOn | pullDownOn, 40'h0);
        chk({hysteresisOff, slewLimit, analogOn}, 18'h01f00);
        rd(8'had, rv);
        chk(rv, 8'hff);
        rd(8'h81, rv);
        chk(rv, 8'h00);
        $display("test reset done");
        for (int it = 0; it < 6; it++)
        begin
            d = 40'({$urandom, $urandom});
            u = 40'({$urandom, $urandom});
            q = 40'({$urandom, $urandom});
            padIn = 40'({$urandom, $urandom});
            an = 8'($urandom);
            if (it == 0) q = u;
            if (it == 1) u = ~q;
            if (it == 5) d = '1;
            if (it == 5) u = '0;
            if (it == 5) q = '0;
            if (it == 5) an = 8'h00;
            for (int p = 0; p < 5; p++)
            begin
                wr(oD[p], d[8*p+:8]);
                wr(oU[p], u[8*p+:8]);
                wr(oP[p], q[8*p+:8]);
            end
            wr(8'hf3, an);
            tk(2);
            m = {32'hffffffff, ~an};
            e = ~((u & q) | ~d) | {32'h0, an};
            chk(padOutEn_n, e);
            chk(padOut & ~e, d & ~e);
            chk(pullUpOn, u & ~q & d & m);
            chk(pullDownOn, q & ~u & d & m);
            chk(analogOn, an);
            for (int p = 0; p < 5; p++)
            begin
                rd(oD[p], rv);
                chk(rv, padIn[8*p+:8]);
                rd(oU[p], rv);
                chk(rv, u[8*p+:8]);
            end
            rv = 8'($urandom);
            wr(8'had, rv);
            tk(2);
            chk(slewLimit, rv[4:0]);
        end
        $display("test pads done");
        wr(8'hae, 8'h97);
        rd(8'hae, rv);
        chk(rv, 8'h00);
        unlock;
        wr(8'hae, 8'h97);
        wr(8'hae, 8'h00);
        rd(8'hae, rv);
        chk(rv, 8'h97);
        compareActive = 3'h7;
        audioOn = 1;
        sysClkTap = 1;
        tk(2);
        chk(lowVoltageResetOff, 1'b1);
        chk(hysteresisOff[4], 1'b1);
        chk({padOutEn_n[29], padOut[29]}, 2'b01);
        chk({padOutEn_n[31:30], padOut[31]}, 3'b011);
        chk(padOutEn_n[11:9], 3'h7);
        unlock;
        wr(8'hae, 8'h00);
        tk(2);
        chk(padOutEn_n[29], 1'b1);
        chk({padOutEn_n[31:30], padOut[31:30]}, 4'b0010);
        chk({padOutEn_n[11:9], padOut[11:9]}, 6'o05);
        chk(lowVoltageResetOff, 1'b0);
        $display("test protected done");
        intPadRaw = 3'h3;
        tk(1);
        chk(intPadClean, 3'h3);
        unlock;
        wr(8'ha7, 8'hab);
        tk(2);
        chk({adcClockDoubler, hysteresisOff[3:0]}, 5'h1b);
        intPadRaw = 3'h4;
        tk(4);
        intPadRaw = 3'h3;
        for (int i = 0; i < 14; i++)
        begin
            tk(1);
            chk(intPadClean, 3'h3);
        end
        intPadRaw = 3'h4;
        tk(7);
        chk(intPadClean, 3'h3);
        tk(1);
        chk(intPadClean, 3'h4);
        $display("test filter done");
        unlock;
        wr(8'ha7, 8'h10);
        for (int p = 0; p < 5; p++)
        begin
            wr(oD[p], 8'h00);
            tk(1);
            for (int i = 0; i < 6 && padOutEn_n[8*p]; i++)
                tk(1);
            if (p == 0) t0 = cyc;
            chk({padOutEn_n[8*p], 3'((cyc - t0) % 5)}, {1'b0, 3'(p)});
        end
        $display("test stagger done");
        summarize;
    end
endmodule
